// ---- src/rpts_pkg.sv ----
package rpts_pkg;

  // strap bus geometry and idle values
  localparam int STRAP_W = 8;
  localparam logic [STRAP_W-1:0] STRAP_IDLE = 8'h00;
  localparam logic [STRAP_W-1:0] STRAP_OE_N_OFF = 8'hFF;
  localparam logic [STRAP_W-1:0] STRAP_OE_N_ON = 8'h00;

  // clock and strap sampling delay after power-on reset release
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRAP_DELAY_NS = 1500;
  localparam int STRAP_CYCLES = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_CNT_W = $clog2(STRAP_CYCLES + 1);
  localparam logic [STRAP_CNT_W-1:0] STRAP_LAST = STRAP_CNT_W'(STRAP_CYCLES - 1);

  // default length of the fast park sequence in clock cycles
  localparam int FAST_PARK_CYCLES = 32;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAIT,
    ST_RUN,
    ST_PARKING,
    ST_PARKED
  } rpts_state_t;

endpackage

// ---- src/rpts_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser; the first stage feeds only the second
module rpts_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // reset value is a constant so an asserted reset never copies a pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- src/rpts_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1: release of power-on reset starts self-configuration
// RULE2: host releases reset only after stable supplies
// RULE3: no output active while power-on reset low
// RULE4: strap pins high-impedance during power-on reset
// RULE5: sample straps after 1.5 us, then drive
// RULE6: board must not pull strap pins high
// RULE7: fast park input low parks mirror array
// RULE8: host uses fast park only as fallback
// RULE9: manufacturing test enable tied to ground
// RULE10: test port reset held low by resistor
// RULE11: synchronise reset and park inputs first
module rpts_top #(
  parameter int FAST_PARK_CYCLES = rpts_pkg::FAST_PARK_CYCLES
) (
  // clock and chip reset
  input wire logic CLK,
  input wire logic RESET,
  // power management side
  input wire logic POWER_ON_RESET_N,
  input wire logic FAST_PARK_N,
  // board ties
  input wire logic MFG_TEST_ENABLE,
  input wire logic TEST_PORT_RESET_N,
  // test strap bus, three signals per pin
  input wire logic [rpts_pkg::STRAP_W-1:0] TEST_STRAP_IN,
  output logic [rpts_pkg::STRAP_W-1:0] TEST_STRAP_OUT,
  output logic [rpts_pkg::STRAP_W-1:0] TEST_STRAP_OE_N,
  // sequencing status
  output logic CONFIG_START,
  output logic SYSTEM_ACTIVE,
  output logic [rpts_pkg::STRAP_W-1:0] TEST_MODE,
  output logic TIE_FAULT,
  // mirror array park control
  output logic MIRROR_PARK_REQ,
  output logic MIRROR_PARKED
);
  import rpts_pkg::*;

  localparam int PARK_CNT_W = $clog2(FAST_PARK_CYCLES + 1);
  localparam logic [PARK_CNT_W-1:0] PARK_LAST = PARK_CNT_W'(FAST_PARK_CYCLES - 1);

  logic por_sync;
  logic park_sync;
  logic por_prev_reg;
  logic por_rise;
  logic wait_done;
  logic park_done;
  logic sample_now;
  rpts_state_t state_reg;
  logic [STRAP_CNT_W-1:0] wait_cnt_reg;
  logic [PARK_CNT_W-1:0] park_cnt_reg;

  // both async pins cross into the clock before any edge is judged
  rpts_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_por_sync (
    .clk(CLK),
    .rst(RESET),
    .d(POWER_ON_RESET_N),
    .q(por_sync)
  ); // see RULE11

  // park input idles high so a chip reset never fakes a park
  rpts_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_park_sync (
    .clk(CLK),
    .rst(RESET),
    .d(FAST_PARK_N),
    .q(park_sync)
  ); // see RULE11

  // edge detector looks only at the synchronised level
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      por_prev_reg <= 1'b0;
    end else begin
      por_prev_reg <= por_sync;
    end
  end

  assign por_rise = por_sync && !por_prev_reg; // see RULE1
  assign wait_done = (wait_cnt_reg == STRAP_LAST);
  assign park_done = (park_cnt_reg == PARK_LAST);
  assign sample_now = por_sync && (state_reg == ST_WAIT) && wait_done;

  // sequencer: a low power-on reset overrides every state
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_HOLD;
      wait_cnt_reg <= '0;
      park_cnt_reg <= '0;
    end else if (!por_sync) begin
      state_reg <= ST_HOLD; // see RULE3
      wait_cnt_reg <= '0;
      park_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_HOLD: begin
          if (por_rise) begin
            state_reg <= ST_WAIT; // see RULE1
            wait_cnt_reg <= '0;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state_reg <= ST_RUN; // see RULE5
          end else begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
          end
        end
        ST_RUN: begin
          if (!park_sync) begin
            state_reg <= ST_PARKING; // see RULE7
            park_cnt_reg <= '0;
          end
        end
        ST_PARKING: begin
          if (park_done) begin
            state_reg <= ST_PARKED;
          end else begin
            park_cnt_reg <= park_cnt_reg + 1'b1;
          end
        end
        ST_PARKED: begin
          // parked until power goes away; only a new reset cycle restarts
          state_reg <= ST_PARKED;
        end
        default: begin
          // three of the eight state codes are unused; fall back to the safe hold
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // one-cycle pulse marking the start of self-configuration
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CONFIG_START <= 1'b0;
    end else begin
      CONFIG_START <= por_sync && por_rise && (state_reg == ST_HOLD); // see RULE1
    end
  end

  // strap pins float during reset, are read once, then driven with the mode
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TEST_MODE <= STRAP_IDLE;
      TEST_STRAP_OUT <= STRAP_IDLE;
      TEST_STRAP_OE_N <= STRAP_OE_N_OFF;
    end else if (!por_sync) begin
      TEST_MODE <= STRAP_IDLE; // see RULE3
      TEST_STRAP_OUT <= STRAP_IDLE;
      TEST_STRAP_OE_N <= STRAP_OE_N_OFF; // see RULE4
    end else if (sample_now) begin
      // a board pull-up here lands the part in a test mode
      TEST_MODE <= TEST_STRAP_IN; // see RULE5
      TEST_STRAP_OUT <= TEST_STRAP_IN;
      TEST_STRAP_OE_N <= STRAP_OE_N_ON; // see RULE5
    end
  end

  // running indication, dropped as soon as parking begins
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SYSTEM_ACTIVE <= 1'b0;
    end else begin
      SYSTEM_ACTIVE <= por_sync && (sample_now || (state_reg == ST_RUN && park_sync)); // see RULE3
    end
  end

  // fast park request and completion; no parking sequence outside power-on
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MIRROR_PARK_REQ <= 1'b0;
      MIRROR_PARKED <= 1'b0;
    end else begin
      MIRROR_PARK_REQ <= por_sync && ((state_reg == ST_RUN && !park_sync) ||
                                      (state_reg == ST_PARKING && !park_done)); // see RULE7
      MIRROR_PARKED <= por_sync && ((state_reg == ST_PARKING && park_done) ||
                                    state_reg == ST_PARKED);
    end
  end

  // flags a board tie that can upset startup; informative only
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TIE_FAULT <= 1'b0;
    end else begin
      TIE_FAULT <= por_sync && (MFG_TEST_ENABLE || TEST_PORT_RESET_N); // see RULE9 see RULE10
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_por_low;
    !por_sync;
  endsequence

  sequence s_released;
    por_rise ##1 por_sync [*8];
  endsequence

  sequence s_park_begin;
    por_sync && state_reg == ST_RUN && !park_sync;
  endsequence

  AST_CONFIG_ON_RISE: assert property (por_rise |=> CONFIG_START && !SYSTEM_ACTIVE) // see RULE1
    else $error("config start missing after reset release");

  AST_INACTIVE_IN_RESET: assert property ( // see RULE3
    s_por_low |=> !CONFIG_START && !SYSTEM_ACTIVE && !MIRROR_PARK_REQ && !MIRROR_PARKED && TEST_MODE == STRAP_IDLE)
    else $error("output active while power-on reset low");

  AST_STRAP_HIZ: assert property (s_por_low |=> TEST_STRAP_OE_N == STRAP_OE_N_OFF) // see RULE4
    else $error("strap pins driven during power-on reset");

  AST_STRAP_WAIT: assert property (s_released |-> TEST_STRAP_OE_N == STRAP_OE_N_OFF) // see RULE5
    else $error("strap pins driven too early");

  AST_STRAP_SAMPLE: assert property ( // see RULE5
    sample_now |=> TEST_STRAP_OE_N == STRAP_OE_N_ON && TEST_MODE == $past(TEST_STRAP_IN) && SYSTEM_ACTIVE)
    else $error("strap sample or drive wrong");

  AST_ACTIVE_AFTER_WAIT: assert property ($rose(SYSTEM_ACTIVE) |-> $past(state_reg) == ST_WAIT) // see RULE1
    else $error("active without configuration wait");

  AST_FAST_PARK: assert property (s_park_begin |=> MIRROR_PARK_REQ && !SYSTEM_ACTIVE) // see RULE7
    else $error("fast park not requested");

  AST_PARK_HOLDS: assert property ((s_park_begin ##1 por_sync [*4]) |-> MIRROR_PARK_REQ) // see RULE7
    else $error("fast park request dropped early");

  AST_PARK_SYNC: assert property (##2 (park_sync == $past(FAST_PARK_N, 2))) // see RULE11
    else $error("park input not two-stage synchronised");

endmodule

// ---- sim/rpts_pmic_model.sv ----
`timescale 1ns/1ps
// power-management side; pins move only on the falling edge, clear of the sampling edge
module rpts_pmic_model (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic rails_ok,
  input wire logic power_fail,
  // pins towards the controller
  output logic por_n = 1'b0,
  output logic park_n = 1'b1
);
  // reset is let go only once the rails are reported stable
  always @(negedge clk) begin
    por_n <= rails_ok;
  end
  // fast park only on a failing supply while rails_ok is high, never as a normal park
  always @(negedge clk) begin
    park_n <= !(power_fail && rails_ok);
  end
endmodule

// ---- sim/rpts_top_tb.sv ----
`timescale 1ns/1ps
module rpts_top_tb;
  import rpts_pkg::*;
  localparam int PARK_N = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rails_ok = 1'b0;
  logic power_fail = 1'b0;
  logic mfg_en = 1'b0;
  logic tport_rst_n = 1'b0;
  logic por_n, park_n, cfg, active, tie_fault, park_req, parked;
  logic [STRAP_W-1:0] board = STRAP_IDLE;
  logic [STRAP_W-1:0] s_in, s_out, s_oe_n, mode;
  // each row: board strapping, then the mode it should select; only row 0 is a legal board
  logic [STRAP_W-1:0] rows [4][2] = '{'{8'h00, 8'h00}, '{8'hA5, 8'hA5}, '{8'h5A, 8'h5A}, '{8'hFF, 8'hFF}};
  int bad_count = 0;
  int checks_done = 0;
  int n;
  // a released pin reads the board level, otherwise the controller's own drive
  assign s_in = (s_oe_n & board) | (~s_oe_n & s_out);
  initial begin
    forever #10 clk = ~clk;
  end
  rpts_pmic_model u_pmic (.clk(clk), .rails_ok(rails_ok), .power_fail(power_fail), .por_n(por_n), .park_n(park_n));
  rpts_top #(.FAST_PARK_CYCLES(PARK_N)) u_dut (.CLK(clk), .RESET(rst), .POWER_ON_RESET_N(por_n),
    .FAST_PARK_N(park_n), .MFG_TEST_ENABLE(mfg_en), .TEST_PORT_RESET_N(tport_rst_n), .TEST_STRAP_IN(s_in),
    .TEST_STRAP_OUT(s_out), .TEST_STRAP_OE_N(s_oe_n), .CONFIG_START(cfg), .SYSTEM_ACTIVE(active),
    .TEST_MODE(mode), .TIE_FAULT(tie_fault), .MIRROR_PARK_REQ(park_req), .MIRROR_PARKED(parked));
  task automatic check(input logic [STRAP_W-1:0] seen, input logic [STRAP_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = cfg;
      1: pick = active;
      2: pick = park_req;
      default: pick = parked;
    endcase
  endfunction
  // bounded wait; n ends as the number of falling edges spent
  task automatic wait_on(input int w, input int limit);
    n = 0;
    while (pick(w) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > limit) begin
        bad_count++;
        $display("Error at %0t: wait timed out", $time);
        final_report();
      end
    end
  endtask
  // idle outputs and released straps while the power-on reset is low
  task automatic check_idle;
    check(s_oe_n, STRAP_OE_N_OFF);
    check({cfg, active, park_req, parked}, 8'h00);
    check(mode, STRAP_IDLE);
  endtask
  // one power cycle with the board strapping b
  task automatic power_up(input logic [STRAP_W-1:0] b, input logic [STRAP_W-1:0] exp);
    board <= b;
    rails_ok <= 1'b0;
    repeat (5) @(negedge clk);
    check_idle();
    rails_ok <= 1'b1;
    wait_on(0, 8);
    check(active, 1'b0);
    @(negedge clk);
    check(cfg, 1'b0);
    wait_on(1, 100);
    check(STRAP_W'(n + 1), STRAP_W'(STRAP_CYCLES));
    check(mode, exp);
    check(s_oe_n, STRAP_OE_N_ON);
    check(s_out, exp);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    check_idle();
    rst <= 1'b0;
    // ordinary cases: one strap pattern per row
    for (int i = 0; i < 4; i++) begin
      power_up(rows[i][0], rows[i][1]);
      $display("strap row %0d done", i);
    end
    // fast park from the run state, then release does not resume
    power_fail <= 1'b1;
    wait_on(2, 8);
    check(active, 1'b0);
    wait_on(3, PARK_N + 2);
    check(STRAP_W'(n), STRAP_W'(PARK_N));
    check(park_req, 1'b0);
    power_fail <= 1'b0;
    repeat (6) @(negedge clk);
    check({parked, active, park_req}, 8'h04);
    $display("fast park test done");
    // board ties flagged when left high
    mfg_en <= 1'b1;
    repeat (4) @(negedge clk);
    check(tie_fault, 1'b1);
    mfg_en <= 1'b0;
    tport_rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(tie_fault, 1'b1);
    tport_rst_n <= 1'b0;
    repeat (4) @(negedge clk);
    check(tie_fault, 1'b0);
    $display("tie test done");
    // power-on reset dropped while parked returns to idle
    rails_ok <= 1'b0;
    repeat (5) @(negedge clk);
    check_idle();
    $display("reset test done");
    final_report();
  end
endmodule
